//--- rtl/etc_pkg.sv
package etc_pkg;
    localparam logic [4:0] CounterValueAddr   = 5'h01;
    localparam logic [7:0] OptionResetValue   = 8'hff;
    localparam logic [3:0] PinDirResetValue   = 4'hf;
    localparam logic [7:0] CounterResetValue  = 8'h00;
    localparam logic [7:0] PrescalerResetValue = 8'h00;
    localparam int         ClockSourceBit     = 5;
    localparam int         SourceEdgeBit      = 4;
    localparam int         PrescalerAssignBit = 3;
    localparam int         RatioLsb           = 0;
    localparam int         RatioWidth         = 3;
    localparam int         CountPinIndex      = 2;
    localparam logic [1:0] WriteInhibitCycles = 2'h2;
    localparam int         SyncDepth          = 3;
endpackage

//--- rtl/etc_edge_sync.sv
`timescale 1ns/10ps
module etc_edge_sync (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    // Pin and edge choice
    input  wire logic pin_i,
    input  wire logic falling_i,
    // Edge event
    output logic      edge_o
);
    logic [etc_pkg::SyncDepth-1:0] sync_q;
    logic [etc_pkg::SyncDepth-1:0] sync_d;
    logic                          level_q;
    logic                          level_d;
    logic                          edge_q;
    logic                          edge_d;

    // A change counts only once stages two and three agree, which filters glitches.
    always_comb begin
        sync_d  = {sync_q[etc_pkg::SyncDepth-2:0], pin_i};
        level_d = level_q;
        edge_d  = 1'b0;
        if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
            level_d = sync_q[2];
            edge_d  = falling_i ? level_q : sync_q[2];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_q  <= '0;
            level_q <= 1'b0;
            edge_q  <= 1'b0;
        end else begin
            sync_q  <= sync_d;
            level_q <= level_d;
            edge_q  <= edge_d;
        end
    end

    assign edge_o = edge_q;
endmodule

//--- rtl/etc_timer.sv
`timescale 1ns/10ps
// Behaviour
// - Source bit clear counts instruction cycles.
// - Counter write inhibits counting two cycles.
// - Source bit set counts external pin edges.
// - Edge bit: clear rising, set falling.
// - Shared prescaler serves counter or watchdog.
// - Assign bit clear counter, set watchdog.
// - Prescaler count never readable or writable.
// - Ratios 1:2 through 1:256 when assigned.
// - Counter is 8-bit read/write at 01h.
// - Source bit set overrides count pin direction.
// - Option bits 2:0 ratio, bit 3 assign.
// - Counter write clears prescaler when assigned.
// - Any reset clears prescaler count.
module etc_timer (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // File register access from the core, one access per instruction cycle
    input  wire logic [4:0] file_addr_i,
    input  wire logic       file_wr_i,
    input  wire logic [7:0] file_wdata_i,
    output logic      [7:0] file_rdata_o,
    // Option and direction loads
    input  wire logic       option_wr_i,
    input  wire logic       pin_dir_wr_i,
    input  wire logic [7:0] wreg_i,
    // Watchdog side
    input  wire logic       watchdog_tick_i,
    input  wire logic       watchdog_clear_i,
    output logic            watchdog_tick_o,
    // Pins
    input  wire logic       external_count_pin_i,
    output logic      [3:0] pin_direction_o,
    output logic      [7:0] option_o
);
    logic [7:0] counter_value_q;
    logic [7:0] counter_value_d;
    logic [1:0] inhibit_q;
    logic [1:0] inhibit_d;

    logic [7:0] option_q;
    logic [7:0] option_d;
    logic [3:0] pin_dir_q;
    logic [3:0] pin_dir_d;

    logic [3:0] pin_dir_out_q;
    logic [3:0] pin_dir_out_d;

    logic [7:0] prescaler_q;
    logic [7:0] prescaler_d;

    logic       wdt_tick_q;
    logic       wdt_tick_d;

    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic       pin_edge;

    etc_edge_sync u_edge_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (external_count_pin_i),
        .falling_i  (option_q[etc_pkg::SourceEdgeBit]),
        .edge_o     (pin_edge)
    );

    // Terminal mask for ratio n: a period of 2^(n+1) source events.
    function automatic logic [7:0] ratio_mask(input logic [2:0] sel);
        logic [8:0] span;
        span       = 9'h001 << (4'(sel) + 4'h1);
        ratio_mask = 8'(span - 9'h001);
    endfunction

    // Shared by the write strobe and the read path, so both decode one address.
    function automatic logic hits_counter(input logic [4:0] addr);
        hits_counter = (addr == etc_pkg::CounterValueAddr);
    endfunction

    // Only the low bits take part, since the count restarts at every terminal value.
    function automatic logic period_done(input logic [7:0] count, input logic [7:0] sel_mask);
        period_done = (count & sel_mask) == sel_mask;
    endfunction

    function automatic logic [7:0] bump(input logic [7:0] value);
        bump = value + 8'h01;
    endfunction

    logic       is_counter_wr;
    logic       source_event;
    logic       to_counter;
    logic [7:0] mask;
    logic       counting;

    logic       presc_clear;
    logic       presc_event;
    logic       presc_done;
    logic       counter_step;

    // Decode of the option bits and of the current file access.
    always_comb begin
        is_counter_wr = file_wr_i && hits_counter(file_addr_i);
        source_event  = option_q[etc_pkg::ClockSourceBit] ? pin_edge : 1'b1;
        to_counter    = !option_q[etc_pkg::PrescalerAssignBit];
        mask          = ratio_mask(option_q[etc_pkg::RatioLsb +: etc_pkg::RatioWidth]);
        // Source events inside the write inhibit are dropped, not deferred.
        counting      = source_event && (inhibit_q == 2'h0);
    end

    // One shared prescaler: its events and its clear come from whichever user owns it.
    always_comb begin
        presc_clear  = to_counter ? is_counter_wr : watchdog_clear_i;
        presc_event  = to_counter ? counting : watchdog_tick_i;
        presc_done   = presc_event && period_done(prescaler_q, mask);
        // A clear in the same cycle as a terminal event wins, and that event is lost.
        counter_step = to_counter ? (presc_done && !presc_clear) : counting;
        prescaler_d  = prescaler_q;
        if (presc_clear) begin
            prescaler_d = etc_pkg::PrescalerResetValue;
        end else if (presc_done) begin
            prescaler_d = etc_pkg::PrescalerResetValue;
        end else if (presc_event) begin
            prescaler_d = bump(prescaler_q);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prescaler_q <= etc_pkg::PrescalerResetValue;
        end else begin
            prescaler_q <= prescaler_d;
        end
    end

    // The watchdog sees its raw ticks whenever the counter owns the prescaler.
    always_comb begin
        wdt_tick_d = to_counter ? watchdog_tick_i : (presc_done && !presc_clear);
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wdt_tick_q <= 1'b0;
        end else begin
            wdt_tick_q <= wdt_tick_d;
        end
    end

    // A write wins over an increment in the same cycle and restarts the inhibit window.
    always_comb begin
        counter_value_d = counter_value_q;
        inhibit_d       = (inhibit_q != 2'h0) ? inhibit_q - 2'h1 : 2'h0;
        if (is_counter_wr) begin
            counter_value_d = file_wdata_i;
            inhibit_d       = etc_pkg::WriteInhibitCycles;
        end else if (counter_step) begin
            counter_value_d = bump(counter_value_q);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            counter_value_q <= etc_pkg::CounterResetValue;
            inhibit_q       <= 2'h0;
        end else begin
            counter_value_q <= counter_value_d;
            inhibit_q       <= inhibit_d;
        end
    end

    // Both loads come from the working register, and neither can be read back.
    always_comb begin
        option_d  = option_wr_i ? wreg_i : option_q;
        pin_dir_d = pin_dir_wr_i ? wreg_i[3:0] : pin_dir_q;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            option_q  <= etc_pkg::OptionResetValue;
            pin_dir_q <= etc_pkg::PinDirResetValue;
        end else begin
            option_q  <= option_d;
            pin_dir_q <= pin_dir_d;
        end
    end

    // The override follows the next option value, so pin and mode change together.
    always_comb begin
        pin_dir_out_d = pin_dir_d;
        if (option_d[etc_pkg::ClockSourceBit]) begin
            pin_dir_out_d[etc_pkg::CountPinIndex] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_dir_out_q <= etc_pkg::PinDirResetValue;
        end else begin
            pin_dir_out_q <= pin_dir_out_d;
        end
    end

    // The prescaler is deliberately absent from every read path.
    always_comb begin
        rdata_d = hits_counter(file_addr_i) ? counter_value_d : 8'h00;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign file_rdata_o    = rdata_q;
    assign pin_direction_o = pin_dir_out_q;
    assign option_o        = option_q;
    assign watchdog_tick_o = wdt_tick_q;
endmodule

//--- tb/etc_timer_properties.sv
`timescale 1ns/10ps
module etc_timer_properties (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // Watched ports
    input  wire logic [4:0] file_addr_i,
    input  wire logic       file_wr_i,
    input  wire logic [7:0] file_wdata_i,
    input  wire logic [7:0] file_rdata_o,
    input  wire logic       option_wr_i,
    input  wire logic       pin_dir_wr_i,
    input  wire logic [7:0] wreg_i,
    input  wire logic       watchdog_tick_i,
    input  wire logic       watchdog_tick_o,
    input  wire logic       external_count_pin_i,
    input  wire logic [3:0] pin_direction_o,
    input  wire logic [7:0] option_o
);
    // Quiet cycles since any file write, any access away from 01h or option load, and since the pin last moved.
    logic [2:0] quiet_q;
    logic [2:0] still_q;
    always_ff @(posedge core_clk_i) begin
        quiet_q <= (rst_i || file_wr_i || option_wr_i || file_addr_i != 5'h01) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
        still_q <= (rst_i || $changed(external_count_pin_i)) ? 3'h0 : still_q + {2'h0, still_q != 3'h7};
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    wr_hold_a: assert property (file_wr_i && file_addr_i == 5'h01 ##1 (file_addr_i == 5'h01 && !file_wr_i) [*2]
        |=> file_rdata_o == $past(file_wdata_i, 3)) else $error("counter write not held");
    inc_timer_a: assert property (quiet_q >= 3'h3 && !option_o[5] && option_o[3]
        |-> file_rdata_o == $past(file_rdata_o) + 8'h01) else $error("timer step missing");
    ctr_hold_a: assert property (quiet_q >= 3'h3 && still_q == 3'h7 && option_o[5]
        |-> $stable(file_rdata_o)) else $error("counter moved without pin edge");
    dir_force_a: assert property (option_o[5] && $past(option_o[5]) |-> pin_direction_o[2])
        else $error("count pin direction not overridden");
    wd_bypass_a: assert property (!option_o[3] && !$past(option_o[3])
        |-> watchdog_tick_o == $past(watchdog_tick_i)) else $error("watchdog tick not bypassed");
    opt_load_a: assert property (option_wr_i |=> option_o == $past(wreg_i))
        else $error("option load wrong");
    rd_other_a: assert property ($past(file_addr_i) != 5'h01 |-> file_rdata_o == 8'h00)
        else $error("other address read not zero");
    rst_clear_a: assert property (disable iff (1'b0) rst_i |=> file_rdata_o == 8'h00 && option_o == 8'hff
        && pin_direction_o == 4'hf && !watchdog_tick_o) else $error("reset values wrong");
endmodule
bind etc_timer etc_timer_properties u_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .file_addr_i(file_addr_i),
    .file_wr_i(file_wr_i), .file_wdata_i(file_wdata_i), .file_rdata_o(file_rdata_o), .option_wr_i(option_wr_i),
    .pin_dir_wr_i(pin_dir_wr_i), .wreg_i(wreg_i), .watchdog_tick_i(watchdog_tick_i),
    .watchdog_tick_o(watchdog_tick_o), .external_count_pin_i(external_count_pin_i),
    .pin_direction_o(pin_direction_o), .option_o(option_o));

//--- tb/test_eight_bit_timer_counter.sv
`timescale 1ns/10ps
module test_eight_bit_timer_counter;
    logic       core_clk_i = 1'b0;
    logic       rst_i      = 1'b1;
    logic [4:0] addr       = 5'h01;
    logic       wr         = 1'b0;
    logic [7:0] wdata      = 8'h00;
    logic       opt_wr     = 1'b0;
    logic       dir_wr     = 1'b0;
    logic [7:0] wreg       = 8'h00;
    logic       wd_tick    = 1'b0;
    logic       wd_clr     = 1'b0;
    logic       pin        = 1'b0;
    logic [7:0] rdata;
    logic       wd_out;
    logic [3:0] dir;
    logic [7:0] opt;
    logic [7:0] v0;
    int         fail_count = 0;
    int         checked    = 0;
    int         cyc        = 0;
    // Windows are whole prescale periods, so the step count does not depend on prescaler phase.
    logic [7:0] r_opt [9]  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
    int         r_cyc [9]  = '{4, 8, 16, 32, 64, 128, 256, 512, 20};
    int         r_inc [9]  = '{2, 2, 2, 2, 2, 2, 2, 2, 20};
    etc_timer uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .file_addr_i(addr), .file_wr_i(wr),
        .file_wdata_i(wdata), .file_rdata_o(rdata), .option_wr_i(opt_wr), .pin_dir_wr_i(dir_wr), .wreg_i(wreg),
        .watchdog_tick_i(wd_tick), .watchdog_clear_i(wd_clr), .watchdog_tick_o(wd_out),
        .external_count_pin_i(pin), .pin_direction_o(dir), .option_o(opt));
    initial forever #50 core_clk_i = ~core_clk_i;
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(negedge core_clk_i) begin
        cyc <= cyc + 1;
        wd_tick <= (cyc % 5 == 0);
        wd_clr <= (cyc % 97 == 0);
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic setopt(input logic [7:0] v);
        wreg = v;
        opt_wr = 1'b1;
        tick(1);
        opt_wr = 1'b0;
    endtask
    task automatic wrf(input logic [4:0] a, input logic [7:0] v);
        addr = a;
        wdata = v;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        addr = 5'h01;
    endtask
    task automatic pincount(input logic [7:0] o, input logic [7:0] exp);
        setopt(o);
        tick(8);
        v0 = rdata;
        repeat (3) begin
            pin = ~pin;
            tick(8);
        end
        chk("pin count", v0 + exp, rdata);
        pin = 1'b0;
        tick(8);
    endtask
    initial begin
        tick(6);
        chk("reset read", 8'h00, rdata);
        chk("reset option", 8'hff, opt);
        chk("reset direction", 8'h0f, {4'h0, dir});
        rst_i = 1'b0;
        tick(4);
        chk("counter after reset", 8'h00, rdata);
        for (int i = 0; i < 9; i++) begin
            setopt(r_opt[i]);
            tick(4);
            v0 = rdata;
            tick(r_cyc[i]);
            chk("timer steps", v0 + r_inc[i][7:0], rdata);
        end
        wrf(5'h01, 8'hfe);
        chk("write inhibit", 8'hfe, rdata);
        tick(2);
        chk("write inhibit", 8'hfe, rdata);
        tick(1);
        chk("first step", 8'hff, rdata);
        tick(1);
        chk("wrap", 8'h00, rdata);
        setopt(8'h07);
        repeat (4) begin
            wrf(5'h01, 8'h40);
            tick(150);
            chk("prescaler cleared", 8'h40, rdata);
        end
        setopt(8'h38);
        tick(4);
        v0 = rdata;
        wrf(5'h02, 8'h55);
        chk("other address", 8'h00, rdata);
        tick(1);
        chk("unmapped write", v0, rdata);
        wreg = 8'h00;
        dir_wr = 1'b1;
        tick(1);
        dir_wr = 1'b0;
        chk("direction override", 8'h04, {4'h0, dir});
        pincount(8'h28, 8'h02);
        pincount(8'h38, 8'h01);
        setopt(8'h20);
        wrf(5'h01, 8'h10);
        repeat (4) begin
            pin = ~pin;
            tick(8);
        end
        chk("prescaled pin count", 8'h11, rdata);
        setopt(8'h08);
        tick(2);
        chk("direction released", 8'h00, {4'h0, dir});
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        tick(1);
        chk("second reset", 8'h00, rdata);
        wrap_up();
    end
endmodule
